// ==== design/opst_pkg.sv ====
package opst_pkg;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_OSCTRL = 5'h04;
    localparam logic [4:0] OFS_IOCTRL = 5'h08;
    localparam logic [4:0] OFS_PRESC = 5'h0c;
    localparam logic [4:0] OFS_PRIM = 5'h10;
    localparam logic [4:0] OFS_SEC = 5'h14;
    localparam logic [4:0] OFS_ROUTE = 5'h18;
    localparam logic [4:0] OFS_SRC = 5'h1c;

    // field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STATUS = 1;
    localparam int CTRL_FSTOP = 2;
    localparam int OS_START = 0;
    localparam int OS_STOP = 1;
    localparam int OS_FLAG = 2;
    localparam int IO_LEVEL = 0;
    localparam int IO_EDGE = 1;
    localparam int IO_TRIGEN = 2;
    localparam int ROUTE_SEL = 0;

    // reset values
    localparam logic [7:0] PRESC_RST = 8'hff;
    localparam logic [7:0] PRIM_RST = 8'hff;
    localparam logic [7:0] SEC_RST = 8'hff;

    // divider phases for the clock/8 count source
    localparam logic [2:0] F8_TICK = 3'h7;
    localparam logic [2:0] F8_MID = 3'h3;

    typedef enum logic [1:0] {
        SRC_F1 = 2'b00,
        SRC_F2 = 2'b01,
        SRC_F8 = 2'b10,
        SRC_COMP = 2'b11
    } opst_src_type;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ARM = 2'b01,
        PH_RUN = 2'b10,
        PH_END = 2'b11
    } opst_phase_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } opst_avs_req_type;

    typedef struct packed {
        logic start;
        logic level_sel;
        logic edge_sel;
        logic trig_en;
        logic route_sel;
        opst_src_type src;
        logic [7:0] pre_rld;
        logic [7:0] pri_rld;
        logic [7:0] sec;
        logic [7:0] pre_cnt;
        logic [7:0] pri_cnt;
        opst_phase_type phase;
        logic ack;
        logic [31:0] rdata;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic irq;
        logic out;
    } opst_state_type;

endpackage : opst_pkg

// ==== design/opst_srcgen.sv ====
module opst_srcgen
    import opst_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // source choice
    input wire opst_src_type src,
    input wire logic comp_uf,
    // count-source enables
    output logic tick,
    output logic mid,
    output logic no_half
);

    logic [2:0] div_reg;
    logic [2:0] div_next;

    assign div_next = div_reg + 3'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= div_next;
        end
    end

    // f1 and companion underflow have no usable half phase
    always_comb begin
        tick = 1'b0;
        mid = 1'b0;
        no_half = 1'b0;
        unique case (src)
            SRC_F1: begin
                tick = 1'b1;
                mid = 1'b1;
                no_half = 1'b1;
            end
            SRC_F2: begin
                tick = div_reg[0];
                mid = !div_reg[0];
            end
            SRC_F8: begin
                tick = (div_reg == F8_TICK);
                mid = (div_reg == F8_MID);
            end
            SRC_COMP: begin
                tick = comp_uf;
                mid = comp_uf;
                no_half = 1'b1;
            end
        endcase
    end

endmodule : opst_srcgen

// ==== design/opst_timer.sv ====
// Contract
// - one pulse on the output pin, started by software or the trigger pin
// - runs once per trigger for the primary period; secondary value unused
// - count source is clock, clock/2, clock/8 or companion underflow
// - counts down from the primary value while the pulse is active
// - underflow reloads both counters, then clears the active flag
// - any stop first reloads the counters from the reload values
// - pulse lasts (n+1)(m+1) count-source periods
// - counting starts only with count start set and a trigger
// - the one-shot ends once the reload after underflow is done
// - stop bit, count start cleared or forced stop end the pulse
// - interrupt raised at pulse end: half a source cycle after underflow on clock/2 and clock/8, at underflow on clock and companion underflow
// - trigger pin acts as trigger only when its enable bit is set
// - prescaler and primary reads return live counter values
// - writes while stopped load both reload value and counter
// - writes while counting load only the reload value
// - level select bit sets the active level of the pulse
// - routing bit steers the pulse to one of two port pins
// - active flag set within one or two source cycles of a trigger
// - triggers during an active one-shot are ignored
// - primary counter decrements on each prescaler underflow
module opst_timer
    import opst_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire opst_avs_req_type avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // trigger pin and companion timer
    input wire logic ext_trigger_irq_pin,
    input wire logic comp_uf,
    // pulse pins
    output logic port_pin_alt_a,
    output logic port_pin_alt_a_oe,
    output logic port_pin_alt_b,
    output logic port_pin_alt_b_oe,
    // status
    output logic oneshot_active_flag,
    output logic timer_irq
);

    opst_state_type s_reg;
    opst_state_type s_next;
    logic tick;
    logic mid;
    logic no_half;
    logic [2:0] idx;
    logic wr;
    logic pin_edge;
    logic active;
    logic sw_trig;
    logic stop_evt;
    logic trig;
    logic uf_evt;
    logic end_evt;

    function automatic logic hit(input logic [2:0] a, input logic [4:0] ofs);
        hit = (a == ofs[4:2]);
    endfunction : hit

    opst_srcgen u_src (
        .clk(clk),
        .rst_n(rst_n),
        .src(s_reg.src),
        .comp_uf(comp_uf),
        .tick(tick),
        .mid(mid),
        .no_half(no_half)
    );

    assign idx = avs_req.address[4:2];
    assign wr = avs_req.write && s_reg.ack && avs_req.byteenable[0];
    assign active = s_reg.phase[1];
    // edge detect looks only at the second and third sync stages
    assign pin_edge = s_reg.edge_sel ? (s_reg.pin_s2 && !s_reg.pin_s3)
                                     : (!s_reg.pin_s2 && s_reg.pin_s3);
    assign sw_trig = wr && hit(idx, OFS_OSCTRL) && avs_req.writedata[OS_START];
    assign stop_evt = wr && ((hit(idx, OFS_OSCTRL) && avs_req.writedata[OS_STOP])
        || (hit(idx, OFS_CTRL) && (!avs_req.writedata[CTRL_START]
        || avs_req.writedata[CTRL_FSTOP])));
    assign trig = s_reg.start && (sw_trig || (s_reg.trig_en && pin_edge));
    assign uf_evt = (s_reg.phase == PH_RUN) && tick && !stop_evt
        && (s_reg.pre_cnt == 8'h00) && (s_reg.pri_cnt == 8'h00);
    assign end_evt = !stop_evt && ((uf_evt && no_half)
        || ((s_reg.phase == PH_END) && mid));

    always_comb begin
        s_next = s_reg;
        s_next.irq = 1'b0;
        s_next.pin_s1 = ext_trigger_irq_pin;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.pin_s3 = s_reg.pin_s2;
        // one wait state: the request is answered on its second cycle
        s_next.ack = (avs_req.read || avs_req.write) && !s_reg.ack;
        s_next.rdata = 32'h0;
        if (avs_req.read && !s_reg.ack) begin
            unique case (idx)
                OFS_CTRL[4:2]: begin
                    s_next.rdata[CTRL_START] = s_reg.start;
                    s_next.rdata[CTRL_STATUS] = s_reg.start;
                end
                OFS_OSCTRL[4:2]: s_next.rdata[OS_FLAG] = active;
                OFS_IOCTRL[4:2]: begin
                    s_next.rdata[IO_LEVEL] = s_reg.level_sel;
                    s_next.rdata[IO_EDGE] = s_reg.edge_sel;
                    s_next.rdata[IO_TRIGEN] = s_reg.trig_en;
                end
                OFS_PRESC[4:2]: s_next.rdata[7:0] = s_reg.pre_cnt;
                OFS_PRIM[4:2]: s_next.rdata[7:0] = s_reg.pri_cnt;
                OFS_SEC[4:2]: s_next.rdata[7:0] = s_reg.sec;
                OFS_ROUTE[4:2]: s_next.rdata[ROUTE_SEL] = s_reg.route_sel;
                OFS_SRC[4:2]: s_next.rdata[1:0] = s_reg.src;
            endcase
        end
        if (wr) begin
            if (hit(idx, OFS_CTRL)) begin
                // forced stop also drops count start
                s_next.start = avs_req.writedata[CTRL_START]
                    && !avs_req.writedata[CTRL_FSTOP];
            end
            if (hit(idx, OFS_IOCTRL)) begin
                s_next.level_sel = avs_req.writedata[IO_LEVEL];
                s_next.edge_sel = avs_req.writedata[IO_EDGE];
                s_next.trig_en = avs_req.writedata[IO_TRIGEN];
            end
            if (hit(idx, OFS_PRESC)) begin
                s_next.pre_rld = avs_req.writedata[7:0];
                if (!active) begin
                    s_next.pre_cnt = avs_req.writedata[7:0];
                end
            end
            if (hit(idx, OFS_PRIM)) begin
                s_next.pri_rld = avs_req.writedata[7:0];
                if (!active) begin
                    s_next.pri_cnt = avs_req.writedata[7:0];
                end
            end
            if (hit(idx, OFS_SEC)) begin
                s_next.sec = avs_req.writedata[7:0];
            end
            if (hit(idx, OFS_ROUTE)) begin
                s_next.route_sel = avs_req.writedata[ROUTE_SEL];
            end
            if (hit(idx, OFS_SRC)) begin
                s_next.src = opst_src_type'(avs_req.writedata[1:0]);
            end
        end
        unique case (s_reg.phase)
            PH_IDLE: begin
                if (trig) begin
                    s_next.phase = PH_ARM;
                end
            end
            PH_ARM: begin
                if (mid) begin
                    s_next.phase = PH_RUN;
                end
            end
            PH_RUN: begin
                if (tick) begin
                    if (s_reg.pre_cnt != 8'h00) begin
                        s_next.pre_cnt = s_reg.pre_cnt - 8'h01;
                    end else begin
                        s_next.pre_cnt = s_reg.pre_rld;
                        s_next.pri_cnt = s_reg.pri_cnt - 8'h01;
                    end
                    if (uf_evt) begin
                        s_next.pri_cnt = s_reg.pri_rld;
                        s_next.phase = no_half ? PH_IDLE : PH_END;
                    end
                end
            end
            PH_END: begin
                if (mid) begin
                    s_next.phase = PH_IDLE;
                end
            end
        endcase
        s_next.irq = end_evt;
        if (stop_evt) begin
            s_next.pre_cnt = s_reg.pre_rld;
            s_next.pri_cnt = s_reg.pri_rld;
            s_next.phase = PH_IDLE;
        end
        // the pin follows the flag directly, so it ends with the interrupt
        s_next.out = s_next.phase[1] ^ s_next.level_sel;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{
                start: 1'b0, level_sel: 1'b0, edge_sel: 1'b0, trig_en: 1'b0,
                route_sel: 1'b0, src: SRC_F1, pre_rld: PRESC_RST,
                pri_rld: PRIM_RST, sec: SEC_RST, pre_cnt: PRESC_RST,
                pri_cnt: PRIM_RST, phase: PH_IDLE, ack: 1'b0, rdata: 32'h0,
                pin_s1: 1'b1, pin_s2: 1'b1, pin_s3: 1'b1, irq: 1'b0,
                out: 1'b0
            };
        end else begin
            s_reg <= s_next;
        end
    end

    assign avs_readdata = s_reg.rdata;
    assign avs_waitrequest = (avs_req.read || avs_req.write) && !s_reg.ack;
    assign port_pin_alt_a = s_reg.out;
    assign port_pin_alt_a_oe = !s_reg.route_sel;
    assign port_pin_alt_b = s_reg.out;
    assign port_pin_alt_b_oe = s_reg.route_sel;
    assign oneshot_active_flag = active;
    assign timer_irq = s_reg.irq;

    // checks; a zero prescaler and primary is never programmed by software
    a_stop_clears_flag: assert property (@(posedge clk) disable iff (!rst_n)
        stop_evt |=> !oneshot_active_flag && !timer_irq)
        else $error("one-shot still active after a stop");

    a_stop_reloads: assert property (@(posedge clk) disable iff (!rst_n)
        stop_evt |=> s_reg.pre_cnt == $past(s_reg.pre_rld)
            && s_reg.pri_cnt == $past(s_reg.pri_rld))
        else $error("counters not reloaded on stop");

    a_uf_reloads: assert property (@(posedge clk) disable iff (!rst_n)
        uf_evt |=> s_reg.pri_cnt == $past(s_reg.pri_rld)
            && s_reg.pre_cnt == $past(s_reg.pre_rld))
        else $error("counters not reloaded at underflow");

    a_irq_at_end: assert property (@(posedge clk) disable iff (!rst_n)
        timer_irq |-> !oneshot_active_flag && $past(oneshot_active_flag)
            && port_pin_alt_a == s_reg.level_sel)
        else $error("interrupt not at pulse end");

    a_idle_level: assert property (@(posedge clk) disable iff (!rst_n)
        !oneshot_active_flag && !$past(wr) |-> port_pin_alt_a == s_reg.level_sel)
        else $error("pin not at inactive level while idle");

    a_write_idle: assert property (@(posedge clk) disable iff (!rst_n)
        wr && hit(idx, OFS_PRIM) && !active && !trig
        |=> s_reg.pri_cnt == $past(avs_req.writedata[7:0]))
        else $error("stopped write missed the counter");

    a_write_busy: assert property (@(posedge clk) disable iff (!rst_n)
        wr && hit(idx, OFS_PRIM) && active && !tick
        |=> s_reg.pri_cnt == $past(s_reg.pri_cnt)
            && s_reg.pri_rld == $past(avs_req.writedata[7:0]))
        else $error("running write touched the counter");

    a_no_retrigger: assert property (@(posedge clk) disable iff (!rst_n)
        active && !stop_evt && !end_evt |=> active)
        else $error("active one-shot disturbed");

    a_flag_bound: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.phase == PH_IDLE && trig && s_reg.src != SRC_COMP
        |-> ##[1:16] (active || s_reg.phase == PH_IDLE))
        else $error("flag not set within two source cycles");

    a_need_start: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.phase == PH_IDLE && !s_reg.start |=> s_reg.phase == PH_IDLE)
        else $error("started without count start");

endmodule : opst_timer

// ==== tb/opst_far_side.sv ====
module opst_far_side (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench control
    input wire logic fire,
    input wire logic idle_lvl,
    // pulse pins and interrupt
    input wire logic pin_a,
    input wire logic pin_a_oe,
    input wire logic pin_b,
    input wire logic pin_b_oe,
    input wire logic irq,
    // toward the timer
    output logic trig_pin,
    output logic comp_uf,
    // load measurements
    output int width,
    output int pulses,
    output logic irq_end
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] gap;
    logic [2:0] low_cnt;
    logic act;
    int run;
    // the load watches only the driven pin; the released one floats at its pull-up
    assign act = (pin_a_oe && (pin_a != idle_lvl)) || (pin_b_oe && (pin_b != idle_lvl));
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 2'h0;
            comp_uf <= 1'b0;
            trig_pin <= 1'b1;
            low_cnt <= 3'h0;
            run <= 0;
            width <= 0;
            pulses <= 0;
            irq_end <= 1'b0;
        end else begin
            // companion underflow every third clock, free running
            gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
            comp_uf <= (gap == 2'h2);
            // low phase held over several clocks so the three-flop synchroniser sees it
            low_cnt <= fire ? 3'h4 : (low_cnt != 3'h0) ? low_cnt - 3'h1 : 3'h0;
            trig_pin <= (low_cnt == 3'h0) && !fire;
            if (act) begin
                run <= run + 1;
            end else if (run != 0) begin
                width <= run;
                pulses <= pulses + 1;
                irq_end <= irq;
                run <= 0;
            end
        end
    end
endmodule : opst_far_side

// ==== tb/opst_timer_bench.sv ====
module opst_timer_bench
    import opst_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    opst_avs_req_type avs_req = '0;
    logic [31:0] avs_readdata;
    logic [31:0] q;
    logic [31:0] rnd = 32'd86928;
    logic avs_waitrequest, trig_pin, comp_uf, pa, pa_oe, pb, pb_oe, flag, irq, irq_end;
    logic fire = 1'b0;
    logic idle_lvl = 1'b0;
    int width, pulses, w0, n, m, p;
    int num_errors = 0;
    int checks_done = 0;

    always #12.5 clk = ~clk;

    opst_timer i_opst_timer (.clk(clk), .rst_n(rst_n), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_trigger_irq_pin(trig_pin), .comp_uf(comp_uf), .port_pin_alt_a(pa),
        .port_pin_alt_a_oe(pa_oe), .port_pin_alt_b(pb), .port_pin_alt_b_oe(pb_oe),
        .oneshot_active_flag(flag), .timer_irq(irq));
    opst_far_side i_opst_far_side (.clk(clk), .rst_n(rst_n), .fire(fire), .idle_lvl(idle_lvl),
        .pin_a(pa), .pin_a_oe(pa_oe), .pin_b(pb), .pin_b_oe(pb_oe), .irq(irq),
        .trig_pin(trig_pin), .comp_uf(comp_uf), .width(width), .pulses(pulses),
        .irq_end(irq_end));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic int period(input int s);
        return (s == 0) ? 1 : (s == 1) ? 2 : (s == 2) ? 8 : 3;
    endfunction : period

    task automatic test_done;
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until the rising edge that sees waitrequest low; data taken there
    task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        avs_req <= '{read: rd, write: !rd, address: a, writedata: {24'h0, d}, byteenable: 4'hf};
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        chk(k < 20, 1);
        q = avs_readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask : bus

    task automatic setup(input int s, input int pn, input int pm);
        bus(0, OFS_SRC, s[7:0]);
        bus(0, OFS_PRESC, pn[7:0]);
        bus(0, OFS_PRIM, pm[7:0]);
        bus(0, OFS_CTRL, 8'h01);
        w0 = pulses;
    endtask : setup

    task automatic pin_fire;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask : pin_fire

    task automatic wait_pulse(input int lo, input int hi, input logic ie);
        int k;
        k = 0;
        while (pulses == w0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        chk(pulses - w0, 1);
        chk(width >= lo && width <= hi, 1);
        chk(irq_end, ie);
        chk(flag, 1'b0);
        w0 = pulses;
    endtask : wait_pulse

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done;
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({flag, pa, pa_oe, pb_oe, irq}, 5'b00100);
        bus(1, OFS_PRESC, 8'h00);
        chk(q, {24'h0, PRESC_RST});
        bus(1, OFS_PRIM, 8'h00);
        chk(q, {24'h0, PRIM_RST});
        // every source; first pass is the shortest legal pulse
        for (int s = 0; s < 4; s++) begin
            rnd = lfsr(rnd);
            n = (s == 0) ? 0 : rnd[1:0];
            m = (s == 0) ? 1 : 1 + rnd[4:2];
            setup(s, n, m);
            bus(1, OFS_PRIM, 8'h00);
            chk(q, m);
            bus(0, OFS_OSCTRL, 8'h01);
            p = period(s);
            wait_pulse(p * (n + 1) * (m + 1), p * (n + 1) * (m + 2), 1);
            bus(1, OFS_PRIM, 8'h00);
            chk(q, m);
        end
        // inverted level on the second pin
        bus(0, OFS_IOCTRL, 8'h01);
        bus(0, OFS_ROUTE, 8'h01);
        idle_lvl <= 1'b1;
        setup(0, 0, 3);
        chk({pa_oe, pb_oe, pb}, 3'b011);
        bus(0, OFS_OSCTRL, 8'h01);
        wait_pulse(4, 5, 1);
        bus(0, OFS_IOCTRL, 8'h00);
        bus(0, OFS_ROUTE, 8'h00);
        idle_lvl <= 1'b0;
        // the three ways of stopping mid-pulse
        for (int k = 0; k < 3; k++) begin
            setup(0, 3, 20);
            bus(0, OFS_OSCTRL, 8'h01);
            repeat (10) @(posedge clk);
            bus(0, (k == 0) ? OFS_OSCTRL : OFS_CTRL, (k == 0) ? 8'h02 : (k == 1) ? 8'h00 : 8'h04);
            wait_pulse(1, 30, 0);
            bus(1, OFS_PRIM, 8'h00);
            chk(q, 20);
        end
        // retrigger and reload write during a running pulse on clock/2
        bus(0, OFS_SEC, 8'h05);
        setup(1, 3, 7);
        bus(0, OFS_OSCTRL, 8'h01);
        bus(0, OFS_OSCTRL, 8'h01);
        // two writes three clocks apart, so one of them falls between ticks
        bus(0, OFS_PRIM, 8'h02);
        bus(0, OFS_PRIM, 8'h02);
        bus(1, OFS_PRIM, 8'h00);
        chk(q <= 7, 1);
        wait_pulse(64, 65, 1);
        bus(1, OFS_PRIM, 8'h00);
        chk(q, 2);
        bus(0, OFS_OSCTRL, 8'h01);
        wait_pulse(24, 25, 1);
        // trigger pin: disabled, falling edge, rising edge, then with counting off
        setup(0, 0, 4);
        pin_fire;
        repeat (20) @(posedge clk);
        chk(pulses - w0, 0);
        bus(0, OFS_IOCTRL, 8'h04);
        pin_fire;
        wait_pulse(5, 6, 1);
        bus(0, OFS_IOCTRL, 8'h06);
        pin_fire;
        wait_pulse(5, 6, 1);
        bus(0, OFS_CTRL, 8'h00);
        pin_fire;
        repeat (20) @(posedge clk);
        chk(pulses - w0, 0);
        chk(flag, 1'b0);
        test_done;
    end
endmodule : opst_timer_bench
